/* File: rtl/dcsd_pkg.sv */
// constants for the dc-motor and stepper drive control block
// assumes 16-bit serial words, address in the top four bits, msb first
package dcsd_pkg;

   // serial word layout
   localparam int WORD_W = 16;            // bits per control word
   localparam int ADDR_MSB = 15;          // top of address field
   localparam int ADDR_LSB = 12;          // bottom of address field
   localparam logic [15:0] REG_RESET = 16'h0000; // all settings off

   // register addresses
   localparam logic [3:0] ADDR_DC5 = 4'h5;  // dc_channel5_control
   localparam logic [3:0] ADDR_DC6 = 4'h6;  // dc_channel6_control
   localparam logic [3:0] ADDR_STEP = 4'h8; // stepper_basic_setup

   // dc channel control fields
   localparam int DC_RUN_BIT = 0;         // 1 drives, 0 stops
   localparam int DC_DIR_BIT = 1;         // 0 a to b, 1 b to a
   localparam int DC_BRAKE_BIT = 2;       // stopped: 0 hi-z, 1 short brake
   localparam int DC_DUTY_LSB = 3;        // duty code low bit
   localparam int DC_DUTY_MSB = 7;        // duty code high bit
   localparam int DC_CHANNELS = 2;        // channels five and six
   localparam int PWM_STEPS = 32;         // serial clocks per pwm period

   // stepper setup fields
   localparam int ST_CUR_LSB = 0;         // peak current code low bit
   localparam int ST_CUR_MSB = 4;         // peak current code high bit
   localparam int ST_DIR_BIT = 5;         // 0 cw, 1 ccw
   localparam int ST_STOP_BIT = 6;        // stop at position mode
   localparam int ST_OE_BIT = 7;          // output enable
   localparam int ST_MODE0_BIT = 8;       // mode select low bit
   localparam int ST_MODE1_BIT = 9;       // mode select high bit
   localparam int ST_CC_BIT = 10;         // constant_current_select

   // peak current reference in millivolts
   localparam logic [9:0] REF_STEP_MV = 10'h014; // 20 mV per code
   localparam logic [9:0] REF_MIN_MV = 10'h064;  // 100 mV floor
   localparam logic [9:0] REF_MAX_MV = 10'h1F4;  // 500 mV ceiling

   // excitation position grid: 64 positions, 16 per quadrant
   localparam logic [3:0] POS_ONE_PHASE = 4'h0; // one coil at full
   localparam logic [3:0] POS_TWO_PHASE = 4'h8; // coils equal
   localparam logic [4:0] QUARTER = 5'h10;      // table index of 90 deg
   localparam logic [5:0] STEP_TWO = 6'h10;     // two-phase stride
   localparam logic [5:0] STEP_HALF = 6'h08;    // 1-2 phase stride
   localparam logic [7:0] FULL_DUTY = 8'hFF;    // 100 percent level

   // driving modes
   typedef enum logic [1:0] {
      MODE_MICRO = 2'b00,                 // micro-step
      MODE_TWO = 2'b01,                   // two-phase excitation
      MODE_HALF = 2'b10                   // 1-2 phase excitation
   } dcsd_mode_e;

endpackage : dcsd_pkg

/* File: rtl/dcsd_drive_ctrl.sv */
// dc-motor bridge control for two channels and stepper basic setup
// assumes a host shifting 16-bit words on the serial pins and a pulse
// engine outside that supplies step ticks and the pulse count
//
// Operation
// [R1] run bit stops or drives dc channel
// [R2] stopped output follows brake select bit
// [R3] direction bit: 0 a to b, 1 b to a
// [R4] brake 0 hi-z, 1 both highs on
// [R5] duty is code/32, code zero is full
// [R6] pwm period is 32 serial clocks
// [R7] host uses stop mode for zero output
// [R8] peak reference code times 20 mv, clamped
// [R9] cw coil two lags, ccw leads
// [R10] stop bit steps until monitor one low
// [R11] pulse count kept during stop mode
// [R12] host sends nothing while stop holds
// [R13] stop at monitor low gives no steps
// [R14] output enable low forces stepper hi-z
// [R15] position kept while output disabled
// [R16] mode bits select micro, two, 1-2
// [R17] reset leaves micro-step mode
// [R18] idle switch: jump or hold per select
// [R19] first pulse jumps to next quadrant
// [R20] one-phase spot counts as cw quadrant
// [R21] full modes: full duty or equal level
// [R22] free counter against duty code
// [R23] latch writes only the addressed register
`timescale 1ns/10ps
`default_nettype none

module dcsd_drive_ctrl (
   input wire logic core_clk_i,              // block clock, 40 MHz
   input wire logic resetn_i,                // async reset, active low
   input wire logic serial_clk_i,            // host serial clock pin
   input wire logic serial_data_i,           // host serial data pin
   input wire logic latch_i,                 // chip select, word on rise
   input wire logic step_tick_i,             // one-cycle step request
   input wire logic pulse_load_i,            // one-cycle count load
   input wire logic [15:0] pulse_count_i,    // pulses for next run
   output logic [1:0] dc_out_a_o,            // phase a level, ch5 ch6
   output logic [1:0] dc_out_a_oe_o,         // phase a drive enable
   output logic [1:0] dc_out_b_o,            // phase b level, ch5 ch6
   output logic [1:0] dc_out_b_oe_o,         // phase b drive enable
   output logic [9:0] peak_current_reference_o, // peak reference, mV
   output logic [7:0] coil1_level_o,         // coil one current level
   output logic coil1_rev_o,                 // coil one reversed
   output logic [7:0] coil2_level_o,         // coil two current level
   output logic coil2_rev_o,                 // coil two reversed
   output logic stepper_en_o,                // 0 puts stepper in hi-z
   output logic position_monitor_one_o,      // low at one-phase spot
   output logic position_monitor_two_o,      // low at two-phase spot
   output logic [15:0] pulses_left_o         // remaining pulse count
);

   // quarter-wave current table, 17 points from 0 to 90 degrees
   function automatic logic [7:0] dcsd_sine_f(input logic [4:0] idx);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         5'h00: v = 8'h00;
         5'h01: v = 8'h19;
         5'h02: v = 8'h32;
         5'h03: v = 8'h4A;
         5'h04: v = 8'h62;
         5'h05: v = 8'h78;
         5'h06: v = 8'h8E;
         5'h07: v = 8'hA2;
         5'h08: v = 8'hB4;
         5'h09: v = 8'hC5;
         5'h0A: v = 8'hD4;
         5'h0B: v = 8'hE1;
         5'h0C: v = 8'hEC;
         5'h0D: v = 8'hF4;
         5'h0E: v = 8'hFA;
         5'h0F: v = 8'hFE;
         default: v = 8'hFF;
      endcase
      return v;
   endfunction : dcsd_sine_f

   // mode decode, used for the held and the incoming word
   function automatic dcsd_pkg::dcsd_mode_e dcsd_mode_f(
      input logic [15:0] w);
      dcsd_pkg::dcsd_mode_e m;
      m = dcsd_pkg::MODE_MICRO;
      if (w[dcsd_pkg::ST_MODE0_BIT] && w[dcsd_pkg::ST_MODE1_BIT]) begin
         m = dcsd_pkg::MODE_HALF;
      end else if (w[dcsd_pkg::ST_MODE0_BIT]) begin
         m = dcsd_pkg::MODE_TWO;
      end
      return m;
   endfunction : dcsd_mode_f

   // pin synchronisers: clock, data, latch
   logic [2:0] pin_meta_q;                   // first stage, read by second
   logic [2:0] pin_sync_q;                   // second stage
   logic [2:0] pin_prev_q;                   // last value for edges

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_meta_q <= 3'h0;
         pin_sync_q <= 3'h0;
         pin_prev_q <= 3'h0;
      end else begin
         pin_meta_q <= {latch_i, serial_data_i, serial_clk_i};
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   wire sclk_rise = pin_sync_q[0] & ~pin_prev_q[0]; // serial clock edge
   wire sdata = pin_sync_q[1];                      // sampled data bit
   wire latch_rise = pin_sync_q[2] & ~pin_prev_q[2]; // word complete

   // shift register, msb first; pwm counter on the same clock edges
   logic [15:0] shift_q;                     // incoming word
   logic [4:0] pwm_cnt_q;                    // free count of serial clocks

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         shift_q <= dcsd_pkg::REG_RESET;
         pwm_cnt_q <= 5'h00;
      end else if (sclk_rise) begin
         shift_q <= {shift_q[14:0], sdata};
         pwm_cnt_q <= pwm_cnt_q + 5'h01;     // wraps at 32 [R6] [R22]
      end
   end

   // address decode of the finished word
   wire [3:0] word_addr = shift_q[dcsd_pkg::ADDR_MSB:dcsd_pkg::ADDR_LSB];
   wire wr_dc5 = latch_rise && (word_addr == dcsd_pkg::ADDR_DC5);
   wire wr_dc6 = latch_rise && (word_addr == dcsd_pkg::ADDR_DC6);
   wire wr_step = latch_rise && (word_addr == dcsd_pkg::ADDR_STEP);
   wire [1:0] wr_dc = {wr_dc6, wr_dc5};      // one strobe per channel

   // control registers; other addresses are ignored here
   logic [15:0] dc_ctrl_q [2];               // dc channel five and six
   logic [15:0] step_q;                      // stepper basic setup

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dc_ctrl_q[0] <= dcsd_pkg::REG_RESET;
         dc_ctrl_q[1] <= dcsd_pkg::REG_RESET;
         step_q <= dcsd_pkg::REG_RESET;      // micro-step at reset [R17]
      end else begin
         if (wr_dc[0]) dc_ctrl_q[0] <= shift_q; // addressed only [R23]
         if (wr_dc[1]) dc_ctrl_q[1] <= shift_q; // [R23]
         if (wr_step) step_q <= shift_q;     // [R23]
      end
   end

   // dc bridges, one generated copy per channel
   genvar g;
   generate
      for (g = 0; g < dcsd_pkg::DC_CHANNELS; g++) begin : gen_dc
         wire run = dc_ctrl_q[g][dcsd_pkg::DC_RUN_BIT];
         wire rev = dc_ctrl_q[g][dcsd_pkg::DC_DIR_BIT];
         wire brake = dc_ctrl_q[g][dcsd_pkg::DC_BRAKE_BIT];
         wire [4:0] duty =
            dc_ctrl_q[g][dcsd_pkg::DC_DUTY_MSB:dcsd_pkg::DC_DUTY_LSB];
         // code zero means always on, so zero output needs stop [R5] [R7]
         wire pwm_on = (duty == 5'h00) || (pwm_cnt_q < duty); // [R22]

         // bridge state; the pwm off phase floats both legs
         always_ff @(posedge core_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               dc_out_a_o[g] <= 1'b0;
               dc_out_b_o[g] <= 1'b0;
               dc_out_a_oe_o[g] <= 1'b0;
               dc_out_b_oe_o[g] <= 1'b0;
            end else if (!run) begin         // stop mode [R1] [R2]
               dc_out_a_o[g] <= brake;       // short brake drives high [R4]
               dc_out_b_o[g] <= brake;
               dc_out_a_oe_o[g] <= brake;    // else hi-z [R4]
               dc_out_b_oe_o[g] <= brake;
            end else begin                   // start mode [R1]
               dc_out_a_o[g] <= ~rev;        // forward pulls a high [R3]
               dc_out_b_o[g] <= rev;         // reverse pulls b high [R3]
               dc_out_a_oe_o[g] <= pwm_on;
               dc_out_b_oe_o[g] <= pwm_on;
            end
         end
      end
   endgenerate

   // stepper settings
   wire [4:0] cur_code = step_q[dcsd_pkg::ST_CUR_MSB:dcsd_pkg::ST_CUR_LSB];
   wire ccw = step_q[dcsd_pkg::ST_DIR_BIT];
   wire stop_mode = step_q[dcsd_pkg::ST_STOP_BIT];
   wire out_en = step_q[dcsd_pkg::ST_OE_BIT];
   wire cc_sel = step_q[dcsd_pkg::ST_CC_BIT];
   dcsd_pkg::dcsd_mode_e mode_now;           // mode in force
   dcsd_pkg::dcsd_mode_e mode_new;           // mode of the incoming word
   assign mode_now = dcsd_mode_f(step_q);
   assign mode_new = dcsd_mode_f(shift_q);

   // peak reference: code times 20 mV, clamped to 100..500 mV
   wire [9:0] ref_raw = 10'(cur_code * dcsd_pkg::REF_STEP_MV);
   wire [9:0] ref_mv = (ref_raw < dcsd_pkg::REF_MIN_MV) ?
      dcsd_pkg::REF_MIN_MV : (ref_raw > dcsd_pkg::REF_MAX_MV) ?
      dcsd_pkg::REF_MAX_MV : ref_raw;        // [R8]

   // excitation position and pulse count
   logic [5:0] pos_q;                        // 64-step excitation spot
   logic [15:0] pulses_q;                    // pulses still to run
   wire [1:0] quad = pos_q[5:4];             // quadrant of the spot
   wire [3:0] sub = pos_q[3:0];              // spot inside the quadrant
   wire two_aligned = (sub == dcsd_pkg::POS_TWO_PHASE);
   wire half_aligned = two_aligned || (sub == dcsd_pkg::POS_ONE_PHASE);

   // a tick moves only when enabled; stop mode runs until monitor low,
   // ignoring the count, and a monitor already low gives no step
   wire tick_ok = step_tick_i && out_en &&        // [R14] [R15]
      (stop_mode ? position_monitor_one_o         // [R10] [R13]
                 : (pulses_q != 16'h0000));
   // the count is untouched while stop mode runs the motor
   wire count_down = tick_ok && !stop_mode;       // [R11]

   // leaving micro-step while idle with full duty jumps within quadrant;
   // a one-phase spot belongs to the quadrant in the cw direction
   wire idle_jump = wr_step && (mode_now == dcsd_pkg::MODE_MICRO) &&
      (mode_new != dcsd_pkg::MODE_MICRO) && (pulses_q == 16'h0000) &&
      !shift_q[dcsd_pkg::ST_CC_BIT];             // [R18] [R20]

   // an off-grid spot in a full mode jumps to the next quadrant
   wire [1:0] next_quad = ccw ? quad - 2'h1 : quad + 2'h1;
   wire [5:0] quad_jump = {next_quad, dcsd_pkg::POS_TWO_PHASE}; // [R19]
   wire [5:0] stride = (mode_now == dcsd_pkg::MODE_TWO) ?
      dcsd_pkg::STEP_TWO : dcsd_pkg::STEP_HALF;
   wire [5:0] grid_step = ccw ? pos_q - stride : pos_q + stride;
   wire [5:0] micro_step = ccw ? pos_q - 6'h01 : pos_q + 6'h01; // [R9]
   wire on_grid = (mode_now == dcsd_pkg::MODE_TWO) ? two_aligned :
      half_aligned;

   logic [5:0] pos_d;                        // next excitation spot
   always_comb begin
      pos_d = pos_q;
      if (idle_jump) begin                   // same quadrant, grid spot
         pos_d = {quad, dcsd_pkg::POS_TWO_PHASE}; // [R18] [R20]
      end else if (tick_ok) begin
         if (mode_now == dcsd_pkg::MODE_MICRO) begin // [R16]
            pos_d = micro_step;
         end else if (on_grid) begin
            pos_d = grid_step;
         end else begin
            pos_d = quad_jump;               // [R19]
         end
      end
   end

   // position, count and monitors
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pos_q <= 6'h00;
         pulses_q <= 16'h0000;
         position_monitor_one_o <= 1'b0;     // spot zero is one-phase
         position_monitor_two_o <= 1'b1;
      end else begin
         pos_q <= pos_d;
         if (pulse_load_i) begin
            pulses_q <= pulse_count_i;
         end else if (count_down) begin
            pulses_q <= pulses_q - 16'h0001; // [R11]
         end
         position_monitor_one_o <= (pos_d[3:0] != dcsd_pkg::POS_ONE_PHASE);
         position_monitor_two_o <= (pos_d[3:0] != dcsd_pkg::POS_TWO_PHASE);
      end
   end

   // coil currents: coil one follows cosine, coil two sine, so coil two
   // lags on cw counting and leads on ccw counting
   wire [1:0] dquad = pos_d[5:4];
   wire [4:0] dsub = {1'b0, pos_d[3:0]};
   wire [4:0] sin_idx = dquad[0] ? dcsd_pkg::QUARTER - dsub : dsub;
   wire [4:0] cos_idx = dquad[0] ? dsub : dcsd_pkg::QUARTER - dsub;
   wire [7:0] sin_mag = dcsd_sine_f(sin_idx); // [R9]
   wire [7:0] cos_mag = dcsd_sine_f(cos_idx);
   // full modes: 100 percent duty, or the micro equal-phase level
   wire [7:0] full_mag = cc_sel ?
      dcsd_sine_f({1'b0, dcsd_pkg::POS_TWO_PHASE}) :
      dcsd_pkg::FULL_DUTY;                   // [R21]
   wire full_mode = (mode_now != dcsd_pkg::MODE_MICRO); // [R16]

   // registered stepper outputs; enable low floats every coil
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         coil1_level_o <= 8'h00;
         coil2_level_o <= 8'h00;
         coil1_rev_o <= 1'b0;
         coil2_rev_o <= 1'b0;
         stepper_en_o <= 1'b0;
         peak_current_reference_o <= dcsd_pkg::REF_MIN_MV;
      end else begin
         stepper_en_o <= out_en;             // overrides all else [R14]
         peak_current_reference_o <= ref_mv; // [R8]
         coil1_rev_o <= dquad[0] ^ dquad[1];
         coil2_rev_o <= dquad[1];
         if (full_mode) begin
            coil1_level_o <= (cos_mag != 8'h00) ? full_mag : 8'h00;
            coil2_level_o <= (sin_mag != 8'h00) ? full_mag : 8'h00;
         end else begin
            coil1_level_o <= cos_mag;
            coil2_level_o <= sin_mag;
         end
      end
   end

   assign pulses_left_o = pulses_q;          // count seen by the engine

endmodule : dcsd_drive_ctrl

`default_nettype wire

/* File: tb/dcsd_drive_ctrl_assertions.sv */
// port checker for the dc and stepper drive control block
// assumes binding into the design top, one core clock domain
`timescale 1ns/10ps
`default_nettype none
module dcsd_drive_ctrl_assertions (
   input wire logic core_clk_i, // block clock
   input wire logic resetn_i, // async reset, active low
   input wire logic latch_i, // serial chip select
   input wire logic step_tick_i, // step request
   input wire logic pulse_load_i, // count load strobe
   input wire logic [15:0] pulse_count_i, // count to load
   input wire logic [1:0] dc_out_a_o, // phase a levels
   input wire logic [1:0] dc_out_a_oe_o, // phase a enables
   input wire logic [1:0] dc_out_b_o, // phase b levels
   input wire logic [1:0] dc_out_b_oe_o, // phase b enables
   input wire logic [9:0] peak_current_reference_o, // peak ref, mV
   input wire logic [7:0] coil1_level_o, // coil one level
   input wire logic [7:0] coil2_level_o, // coil two level
   input wire logic stepper_en_o, // stepper enable
   input wire logic position_monitor_one_o, // one-phase spot, low
   input wire logic position_monitor_two_o, // two-phase spot, low
   input wire logic [15:0] pulses_left_o // remaining pulses
);
   // everything here lives on the core clock
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   a_bridge_pair: assert property (dc_out_a_oe_o == dc_out_b_oe_o)
      else $error("bridge phase enables differ");
   a_no_low_pair: assert property (
      (dc_out_a_oe_o & ~dc_out_a_o & ~dc_out_b_o) == 2'b00)
      else $error("driven bridge with both phases low");
   a_ref_clamp: assert property (
      peak_current_reference_o >= dcsd_pkg::REF_MIN_MV &&
      peak_current_reference_o <= dcsd_pkg::REF_MAX_MV &&
      (peak_current_reference_o % dcsd_pkg::REF_STEP_MV) == 10'h000)
      else $error("peak reference off grid");
   a_idle_count: assert property (
      !step_tick_i && !pulse_load_i |=> $stable(pulses_left_o))
      else $error("pulse count moved without cause");
   a_load_count: assert property (
      pulse_load_i |=> pulses_left_o == $past(pulse_count_i))
      else $error("pulse count not loaded");
   a_tick_count: assert property (step_tick_i && !pulse_load_i |=>
      pulses_left_o == $past(pulses_left_o) ||
      pulses_left_o == $past(pulses_left_o) - 16'h0001)
      else $error("pulse count moved by more than one");
   a_disabled_hold: assert property (
      !stepper_en_o && step_tick_i |=>
      $stable(position_monitor_one_o) && $stable(position_monitor_two_o) &&
      $stable(pulses_left_o))
      else $error("disabled stepper moved");
   a_monitor_apart: assert property (
      position_monitor_one_o || position_monitor_two_o)
      else $error("both position monitors low");
   a_equal_coils: assert property (
      !position_monitor_two_o |-> coil1_level_o == coil2_level_o)
      else $error("coil levels differ at two-phase spot");
   a_still_rest: assert property ((!step_tick_i && !latch_i) [*6] |=>
      $stable(position_monitor_one_o) && $stable(position_monitor_two_o))
      else $error("position moved without step or write");

   // main scenarios seen at least once
   c_brake: cover property (
      dc_out_a_oe_o[0] && dc_out_a_o[0] && dc_out_b_o[0]);
   c_two_phase: cover property (!position_monitor_two_o);
   c_step: cover property (step_tick_i && stepper_en_o);
endmodule : dcsd_drive_ctrl_assertions

bind dcsd_drive_ctrl dcsd_drive_ctrl_assertions dcsd_drive_ctrl_assertions_i (
   .core_clk_i(core_clk_i), .resetn_i(resetn_i), .latch_i(latch_i),
   .step_tick_i(step_tick_i), .pulse_load_i(pulse_load_i),
   .pulse_count_i(pulse_count_i), .dc_out_a_o(dc_out_a_o),
   .dc_out_a_oe_o(dc_out_a_oe_o), .dc_out_b_o(dc_out_b_o),
   .dc_out_b_oe_o(dc_out_b_oe_o),
   .peak_current_reference_o(peak_current_reference_o),
   .coil1_level_o(coil1_level_o), .coil2_level_o(coil2_level_o),
   .stepper_en_o(stepper_en_o),
   .position_monitor_one_o(position_monitor_one_o),
   .position_monitor_two_o(position_monitor_two_o),
   .pulses_left_o(pulses_left_o));
`default_nettype wire

/* File: tb/dcsd_host_model.sv */
// host controller model shifting 16-bit control words, msb first
// assumes a 200 ns serial period; the serial clock rests low between frames
`timescale 1ns/10ps
`default_nettype none
module dcsd_host_model (
   output logic serial_clk_o, // serial clock, low outside frames except in clock_once
   output logic serial_data_o, // serial data, msb first
   output logic latch_o // chip select, word commits on rise
);
   // idle levels; data never rests on the last bit sent
   initial begin
      serial_clk_o = 1'b0;
      serial_data_o = 1'b1;
      latch_o = 1'b0;
   end

   // one whole word, then a latch pulse well after the last rise
   task automatic send_word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         serial_data_o = w[i];
         #100 serial_clk_o = 1'b1;
         #100 serial_clk_o = 1'b0;
      end
      #100 latch_o = 1'b1;
      serial_data_o = ~w[0];
      #100 latch_o = 1'b0;
   endtask : send_word

   // a lone clock period with no latch, advancing the pwm count
   task automatic clock_once();
      #50 serial_clk_o = 1'b1;
      #100 serial_clk_o = 1'b0;
      #50 serial_data_o = ~serial_data_o;
   endtask : clock_once
endmodule : dcsd_host_model
`default_nettype wire

/* File: tb/dcsd_drive_ctrl_tb.sv */
// self-checking bench for the dc and stepper drive control block
// assumes the host model for serial writes; ticks driven on falling edges
`timescale 1ns/10ps
`default_nettype none
module dcsd_drive_ctrl_tb;
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
   mismatches++; $display("mismatch at %0t: got %h expected %h", \
   $time, got, exp); end end
   logic core_clk_i = 1'b0; // block clock
   logic resetn_i; // reset, active low
   logic step_tick_i; // step request
   logic pulse_load_i; // count load
   logic [15:0] pulse_count_i; // count value
   wire logic serial_clk; // host serial clock
   wire logic serial_data; // host serial data
   wire logic latch; // host chip select
   logic [1:0] a, a_oe, b, b_oe; // bridge outputs
   logic [9:0] peak; // peak reference
   logic [7:0] c1, c2; // coil levels
   logic c1_rev, c2_rev, en, mon1, mon2; // stepper state
   logic [15:0] left; // pulses left
   int mismatches = 0; // failed comparisons
   int num_checks = 0; // all comparisons

   always #12.5 core_clk_i = ~core_clk_i;

   dcsd_host_model dcsd_host_model_i (.serial_clk_o(serial_clk),
      .serial_data_o(serial_data), .latch_o(latch));
   dcsd_drive_ctrl dcsd_drive_ctrl_i (.core_clk_i(core_clk_i),
      .resetn_i(resetn_i), .serial_clk_i(serial_clk),
      .serial_data_i(serial_data), .latch_i(latch),
      .step_tick_i(step_tick_i), .pulse_load_i(pulse_load_i),
      .pulse_count_i(pulse_count_i), .dc_out_a_o(a), .dc_out_a_oe_o(a_oe),
      .dc_out_b_o(b), .dc_out_b_oe_o(b_oe), .peak_current_reference_o(peak),
      .coil1_level_o(c1), .coil1_rev_o(c1_rev), .coil2_level_o(c2),
      .coil2_rev_o(c2_rev), .stepper_en_o(en),
      .position_monitor_one_o(mon1), .position_monitor_two_o(mon2),
      .pulses_left_o(left));

   // write a word, then allow sync, commit and output latency to land
   task automatic wr(input logic [15:0] w);
      dcsd_host_model_i.send_word(w);
      repeat (8) @(negedge core_clk_i);
   endtask : wr

   // single-cycle step requests, spaced so outputs settle between them
   task automatic tick(input int n);
      repeat (n) begin
         @(negedge core_clk_i) step_tick_i = 1'b1;
         @(negedge core_clk_i) step_tick_i = 1'b0;
         repeat (2) @(negedge core_clk_i);
      end
   endtask : tick

   task automatic load(input logic [15:0] n);
      @(negedge core_clk_i) pulse_load_i = 1'b1;
      pulse_count_i = n;
      @(negedge core_clk_i) pulse_load_i = 1'b0;
   endtask : load

   function automatic logic [15:0] dcw(input logic [3:0] ad,
      input logic [4:0] duty, input logic brake, input logic dir,
      input logic run);
      return {ad, 4'h0, duty, brake, dir, run};
   endfunction : dcw

   // mode is {upper bit, lower bit} of the mode select pair
   function automatic logic [15:0] stw(input logic cc, input logic [1:0] md,
      input logic oe, input logic stop, input logic dir,
      input logic [4:0] cur);
      return {dcsd_pkg::ADDR_STEP, 1'b0, cc, md, oe, stop, dir, cur};
   endfunction : stw

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   // hang guard
   initial begin
      repeat (100000) @(posedge core_clk_i);
      mismatches++;
      test_done();
   end

   initial begin
      logic [4:0] duties [4] = '{5'h00, 5'h01, 5'h08, 5'h1F}; // edge codes
      logic [4:0] codes [6] = '{5'h00, 5'h05, 5'h06, 5'h0A, 5'h19, 5'h1F};
      int on_cnt;
      int k;
      int e;
      logic [7:0] held;
      resetn_i = 1'b0;
      step_tick_i = 1'b0;
      pulse_load_i = 1'b0;
      pulse_count_i = 16'h0000;
      repeat (4) @(negedge core_clk_i);
      resetn_i = 1'b1;
      @(negedge core_clk_i);
      `CHK({a_oe, b_oe, en}, 5'h00)
      `CHK(peak, dcsd_pkg::REF_MIN_MV)
      // stopped channel five: short brake, then hi-z; six untouched
      wr(dcw(dcsd_pkg::ADDR_DC5, 5'h00, 1'b1, 1'b0, 1'b0));
      `CHK({a[0], b[0], a_oe[0], b_oe[0], a_oe[1]}, 5'h1E)
      wr(dcw(dcsd_pkg::ADDR_DC5, 5'h00, 1'b0, 1'b0, 1'b0));
      `CHK({a_oe[0], b_oe[0]}, 2'b00)
      // duty codes on channel six over one full pwm period each
      foreach (duties[j]) begin
         wr(dcw(dcsd_pkg::ADDR_DC6, duties[j], 1'b0, j[0], 1'b1));
         on_cnt = 0;
         repeat (32) begin
            dcsd_host_model_i.clock_once();
            @(negedge core_clk_i);
            if (a_oe[1] === 1'b1 && a[1] === ~j[0] && b[1] === j[0]) on_cnt++;
         end
         e = (duties[j] == 5'h00) ? 32 : int'(duties[j]);
         `CHK(on_cnt, e)
      end
      // zero output is asked for by stop mode, never by duty
      wr(dcw(dcsd_pkg::ADDR_DC6, 5'h00, 1'b0, 1'b0, 1'b0));
      `CHK(a_oe, 2'b00)
      wr(16'h7FFF);
      `CHK(a_oe, 2'b00)
      // peak reference scaling and clamping
      foreach (codes[j]) begin
         wr(stw(1'b0, 2'b00, 1'b0, 1'b0, 1'b0, codes[j]));
         e = int'(codes[j]) * 20;
         e = (e < 100) ? 100 : ((e > 500) ? 500 : e);
         `CHK(peak, 10'(e))
      end
      // micro-step one position clockwise, then two counter-clockwise
      wr(stw(1'b0, 2'b00, 1'b1, 1'b0, 1'b0, 5'h0A));
      `CHK(en, 1'b1)
      load(16'h0004);
      tick(1);
      `CHK({left, mon1, mon2, c2_rev}, {16'h0003, 3'b110})
      wr(stw(1'b0, 2'b00, 1'b1, 1'b0, 1'b1, 5'h0A));
      tick(2);
      `CHK({left, c2_rev}, {16'h0001, 1'b1})
      // disabled outputs ignore steps and keep the position
      wr(stw(1'b0, 2'b00, 1'b0, 1'b0, 1'b1, 5'h0A));
      tick(1);
      `CHK({en, left}, {1'b0, 16'h0001})
      wr(stw(1'b0, 2'b00, 1'b1, 1'b0, 1'b1, 5'h0A));
      `CHK({mon1, c1_rev, c2_rev}, 3'b101)
      // first pulse after a switch jumps to the next quadrant
      wr(stw(1'b0, 2'b11, 1'b1, 1'b0, 1'b0, 5'h0A));
      tick(1);
      `CHK({mon2, left}, {1'b0, 16'h0000})
      wr(stw(1'b0, 2'b00, 1'b1, 1'b0, 1'b0, 5'h0A));
      load(16'h0001);
      tick(1);
      // switch to full modes with no pulses pending
      load(16'h0000);
      wr(stw(1'b0, 2'b01, 1'b1, 1'b0, 1'b0, 5'h0A));
      `CHK({mon2, c1, c2}, {1'b0, 16'hFFFF})
      wr(stw(1'b1, 2'b11, 1'b1, 1'b0, 1'b0, 5'h0A));
      `CHK({mon2, c1, c2}, {1'b0, 16'hB4B4})
      // stop mode: steps run to the one-phase spot and then hold
      load(16'h0005);
      wr(stw(1'b0, 2'b00, 1'b1, 1'b1, 1'b0, 5'h0A));
      k = 0;
      while (mon1 === 1'b1 && k < 12) begin
         tick(1);
         k++;
      end
      `CHK(k, 8)
      held = c1;
      tick(2);
      `CHK({mon1, c1, left}, {1'b0, held, 16'h0005})
      // no writes while stop holds; a fresh reset ends the run
      resetn_i = 1'b0;
      repeat (4) @(negedge core_clk_i);
      resetn_i = 1'b1;
      @(negedge core_clk_i);
      `CHK({en, mon1, mon2, left}, {3'b001, 16'h0000})
      test_done();
   end
endmodule : dcsd_drive_ctrl_tb
`default_nettype wire
